// >>> rtl/mdc_dma_ctrl.sv
`timescale 1ns/1ps
// word buffer with a registered output stage
module mdc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // filling side
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  // push and pop decisions
  assign push = inValid && inReady;
  assign pop = (count != '0) && (!outValid || outReady);
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers, fill level and honest ready
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      count <= next_count;
      inReady <= next_count < (PW+1)'(DEPTH);
    end
  end

  // output stage, stalls while the drain holds ready low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (pop) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule

// channel control: active bits, pointer, indirect registers, offsets and flags
module mdc_dma_ctrl import mdc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // peripheral data source
  input wire logic srcValid,
  input wire logic [DATA_W-1:0] srcData,
  output logic srcReady,
  // data ram side
  output logic memValid,
  output logic [DATA_W-1:0] memData,
  output logic [CH_W-1:0] memChan,
  output logic [OFS_W-1:0] memOffset,
  input wire logic memReady
);
  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0] fullFlag;
  logic [NUM_CH-1:0] halfFlag;
  logic [NUM_CH-1:0] wrapEn;
  logic [NUM_CH-1:0] hitLast;
  logic [NUM_CH-1:0] hitHalf;
  logic [CH_W-1:0] pointer;
  logic [7:0] chanConfig [NUM_CH];
  logic [OFS_W-1:0] size [NUM_CH];
  logic [OFS_W-1:0] offset [NUM_CH];
  logic [NUM_CH-1:0] eligible;
  logic [CH_W-1:0] curChan;
  logic found;
  logic push;
  logic [FIFO_W-1:0] fifoOut;
  logic ptrValid;

  // write strobe for one address
  function automatic logic wrHit(input logic [7:0] a);
    return sfrWrite && (sfrAddr == a);
  endfunction

  // point at which the mid-point flag fires
  function automatic logic [OFS_W-1:0] midPoint(input logic [OFS_W-1:0] s);
    return s >> 1; // odd sizes: (s-1)/2 equals s>>1
  endfunction

  // lowest-numbered running, unstalled channel gets the source
  always_comb begin
    found = 1'b0;
    curChan = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        curChan = CH_W'(i);
      end
    end
  end

  assign ptrValid = pointer != SEL_INVALID;
  assign push = found && srcValid && srcReady;

  // channel pointer, upper bits dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pointer <= '0;
    end else if (wrHit(ADDR_POINTER)) begin
      pointer <= sfrWrData[CH_W-1:0];
    end
  end

  // per-channel state
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    logic sel;
    assign sel = ptrValid && (pointer == CH_W'(i));
    assign eligible[i] = active[i] && !chanConfig[i][STALL_BIT];
    assign hitLast[i] = push && (curChan == CH_W'(i)) && (offset[i] == size[i] - 1'b1);
    assign hitHalf[i] = push && (curChan == CH_W'(i)) && (offset[i] == midPoint(size[i]));

    // active bit: software start wins over completion
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        active[i] <= 1'b0;
      end else if (wrHit(ADDR_ACTIVE) && sfrWrData[i]) begin
        active[i] <= 1'b1;
      end else if (hitLast[i] && !wrapEn[i]) begin
        active[i] <= 1'b0;
      end
    end

    // address offset counter
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        offset[i] <= RST_WORD;
      end else if (wrHit(ADDR_ACTIVE) && sfrWrData[i]) begin
        offset[i] <= RST_WORD;
      end else if (hitLast[i]) begin
        offset[i] <= RST_WORD;
      end else if (push && curChan == CH_W'(i)) begin
        offset[i] <= offset[i] + 1'b1;
      end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        fullFlag[i] <= 1'b0;
        halfFlag[i] <= 1'b0;
      end else begin
        fullFlag[i] <= (wrHit(ADDR_FULL) ? sfrWrData[i] & fullFlag[i] : fullFlag[i]) | hitLast[i];
        halfFlag[i] <= (wrHit(ADDR_HALF) ? sfrWrData[i] & halfFlag[i] : halfFlag[i]) | hitHalf[i];
      end
    end

    // indirect mode, config and size registers
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        wrapEn[i] <= 1'b0;
        chanConfig[i] <= RST_REG;
        size[i] <= RST_WORD;
      end else if (sel) begin
        if (wrHit(ADDR_MODE)) wrapEn[i] <= sfrWrData[WRAP_BIT];
        if (wrHit(ADDR_CONFIG)) chanConfig[i] <= sfrWrData;
        if (wrHit(ADDR_SIZE_LO)) size[i][7:0] <= sfrWrData;
        if (wrHit(ADDR_SIZE_HI)) size[i][15:8] <= sfrWrData;
      end
    end
  end

  // registered read data, unmapped or invalid pointer reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfrRdData <= RST_REG;
    end else if (sfrRead) begin
      sfrRdData <= RST_REG;
      case (sfrAddr)
        ADDR_ACTIVE: sfrRdData <= {1'b0, active};
        ADDR_POINTER: sfrRdData <= {5'h00, pointer};
        ADDR_FULL: sfrRdData <= {1'b0, fullFlag};
        ADDR_HALF: sfrRdData <= {1'b0, halfFlag};
        default: begin
          if (ptrValid) begin
            case (sfrAddr)
              ADDR_MODE: sfrRdData <= {7'h00, wrapEn[pointer]};
              ADDR_CONFIG: sfrRdData <= chanConfig[pointer];
              ADDR_SIZE_LO: sfrRdData <= size[pointer][7:0];
              ADDR_SIZE_HI: sfrRdData <= size[pointer][15:8];
              ADDR_OFS_LO: sfrRdData <= offset[pointer][7:0];
              ADDR_OFS_HI: sfrRdData <= offset[pointer][15:8];
              default: sfrRdData <= RST_REG;
            endcase
          end
        end
      endcase
    end
  end

  // words tagged with channel and offset toward the data ram
  mdc_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .inValid(found && srcValid),
    .inData({curChan, offset[curChan], srcData}),
    .inReady(srcReady),
    .outValid(memValid),
    .outData(fifoOut),
    .outReady(memReady)
  );

  assign memChan = fifoOut[FIFO_W-1 -: CH_W];
  assign memOffset = fifoOut[DATA_W +: OFS_W];
  assign memData = fifoOut[DATA_W-1:0];
endmodule

// >>> rtl/mdc_pkg.sv
// Overview of operation
// - writing one to a channel's active bit starts a transfer on that channel, writing zero does nothing, channels 0-6.
// - a channel's active bit reads one while its transfer runs and zero while it is idle.
// - pointer bits 2:0 pick the channel for indirect accesses, 000-110 are channels 0-6 and 111 is invalid.
// - pointer bits 7:3 read zero and ignore writes.
// - the mode register is indirect and every access reaches the copy of the pointed channel; with pointer 111 the code drops writes and reads zero.
// - each channel's offset starts at zero and steps once per transfer up to size minus one.
// - reaching size minus one sets that channel's full-length flag and, with wrap off, completes the transfer.
// - mode bit 0 turns wrap on for its channel.
// - with wrap on, reaching the final offset returns the offset to zero.
// - the full-length flag sets at offset size minus one and clears only by software write or reset.
// - the mid-point flag sets at offset size/2 for even sizes and (size-1)/2 for odd sizes.
// - the stall bit halts the pointed channel until software clears it.
package mdc_pkg;
  localparam int NUM_CH = 7;
  localparam int DATA_W = 8;
  localparam int OFS_W = 16;
  localparam int CH_W = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = CH_W + OFS_W + DATA_W;
  // register addresses on the special function register port
  localparam logic [7:0] ADDR_ACTIVE = 8'h00;
  localparam logic [7:0] ADDR_POINTER = 8'h01;
  localparam logic [7:0] ADDR_MODE = 8'h02;
  localparam logic [7:0] ADDR_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_SIZE_LO = 8'h04;
  localparam logic [7:0] ADDR_SIZE_HI = 8'h05;
  localparam logic [7:0] ADDR_OFS_LO = 8'h06;
  localparam logic [7:0] ADDR_OFS_HI = 8'h07;
  localparam logic [7:0] ADDR_FULL = 8'h08;
  localparam logic [7:0] ADDR_HALF = 8'h09;
  // field positions and reset values
  localparam int WRAP_BIT = 0;
  localparam int STALL_BIT = 5;
  localparam logic [CH_W-1:0] SEL_INVALID = 3'h7;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [OFS_W-1:0] RST_WORD = 16'h0000;
endpackage

// >>> verification/mdc_dma_ctrl_props.sv
`timescale 1ns/1ps
// port-level checks on the channel control block
module mdc_dma_ctrl_props import mdc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [7:0] sfrWrData,
  input wire logic [7:0] sfrRdData,
  // data paths
  input wire logic srcValid,
  input wire logic [DATA_W-1:0] srcData,
  input wire logic srcReady,
  input wire logic memValid,
  input wire logic [DATA_W-1:0] memData,
  input wire logic [CH_W-1:0] memChan,
  input wire logic [OFS_W-1:0] memOffset,
  input wire logic memReady
);
  logic [CH_W-1:0] ptrM;
  wire rdP = sfrRead && sfrAddr == ADDR_POINTER;
  // mirror of the channel pointer field
  always_ff @(posedge clk) begin
    if (sys_rst) ptrM <= 3'h0;
    else if (sfrWrite && sfrAddr == ADDR_POINTER) ptrM <= sfrWrData[2:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST: assert property (disable iff (1'b0) sys_rst |=> !sfrRdData && !memValid && !srcReady)
    else $error("outputs not cleared by reset");
  AST_RDHOLD: assert property (!sfrRead |=> $stable(sfrRdData))
    else $error("read data moved without a read");
  AST_PTR: assert property (rdP |=> sfrRdData == {5'h00, $past(ptrM)})
    else $error("pointer readback wrong");
  AST_ACT7: assert property (sfrRead && sfrAddr == ADDR_ACTIVE |=> !sfrRdData[7])
    else $error("active bit 7 not zero");
  AST_MODE: assert property (sfrRead && sfrAddr == ADDR_MODE |=> sfrRdData[7:1] == 7'h00)
    else $error("mode reserved bits not zero");
  AST_HOLD: assert property (memValid && !memReady |=> memValid && $stable({memData, memChan, memOffset}))
    else $error("word dropped or changed while stalled");
  AST_CHAN: assert property (memValid |-> memChan != SEL_INVALID)
    else $error("word from invalid channel");
  AST_DROP: assert property ($fell(memValid) |-> $past(memReady))
    else $error("word withdrawn without acceptance");
  cover property (memValid && memReady);
  cover property (!srcReady);
  cover property (rdP);
endmodule

// >>> verification/mdc_dma_ctrl_test.sv
`timescale 1ns/1ps
module mdc_dma_ctrl_test import mdc_pkg::*;;
  logic clk, sys_rst, sfrWrite, sfrRead, srcValid, hold, rdLat, srcReady, memValid, memReady;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, srcData, memData;
  logic [CH_W-1:0] memChan;
  logic [OFS_W-1:0] memOffset;
  logic [7:0] rdq[$];
  logic [FIFO_W-1:0] mq[$];
  int err_count = 0;
  int n_tests = 0;
  int sz;
  mdc_dma_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .srcValid(srcValid),
    .srcData(srcData), .srcReady(srcReady), .memValid(memValid), .memData(memData),
    .memChan(memChan), .memOffset(memOffset), .memReady(memReady));
  mdc_ram_model ram (.clk(clk), .hold(hold), .memReady(memReady));
  // 50 MHz clock
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic cmpR(input logic [7:0] e, input logic [7:0] a);
    n_tests++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t reg %h not %h", $time, a, e);
    end
  endtask
  task automatic cmpM(input logic [FIFO_W-1:0] e, input logic [FIFO_W-1:0] a);
    n_tests++;
    if (a !== e) begin
      err_count++;
      $display("[ERR] %0t word %h not %h", $time, a, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {sfrWrite, sfrAddr, sfrWrData} = {1'b1, a, d};
    @(posedge clk) #1 sfrWrite = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq.push_back(e);
    @(posedge clk) #1 {sfrRead, sfrAddr} = {1'b1, a};
    @(posedge clk) #1 sfrRead = 0;
  endtask
  // back-to-back words, each held until taken
  task automatic send(input int n, input logic [CH_W-1:0] ch, input int o);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      logic [7:0] d;
      d = 8'($urandom);
      mq.push_back({ch, OFS_W'((o + i) % sz), d});
      #1 {srcValid, srcData} = {1'b1, d};
      while (srcReady !== 1'b1) @(posedge clk) #1;
      @(posedge clk);
    end
    #1 srcValid = 0;
  endtask
  task automatic drain;
    for (int i = 0; i < 500 && mq.size() > 0; i++) @(posedge clk);
    if (mq.size() > 0) begin
      err_count++;
      $display("[ERR] %0t words still owed", $time);
    end
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // result watcher: read data and accepted words
  always @(posedge clk) rdLat <= sfrRead;
  always @(negedge clk) begin
    if (rdLat === 1'b1) cmpR(rdq.pop_front(), sfrRdData);
    if (memValid === 1'b1 && memReady === 1'b1) begin
      if (mq.size() == 0) begin
        err_count++;
        $display("[ERR] %0t word with none expected", $time);
      end else begin
        cmpM(mq.pop_front(), {memChan, memOffset, memData});
      end
    end
  end
  // watchdog
  initial begin
    #200us;
    err_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {sys_rst, sfrWrite, sfrRead, srcValid, hold} = 5'b10000;
    {sfrAddr, sfrWrData, srcData} = 24'h000000;
    void'($urandom(90));
    repeat (20) @(posedge clk);
    #1 sys_rst = 0;
    rd(ADDR_ACTIVE, 8'h00); rd(ADDR_POINTER, 8'h00); rd(ADDR_MODE, 8'h00); rd(8'h3c, 8'h00);
    wr(ADDR_POINTER, 8'hfe); rd(ADDR_POINTER, 8'h06);
    wr(ADDR_POINTER, 8'hff); rd(ADDR_MODE, 8'h00);
    for (int c = 0; c < NUM_CH; c++) begin
      wr(ADDR_POINTER, 8'(c)); wr(ADDR_MODE, 8'(c % 2));
    end
    for (int c = 0; c < NUM_CH; c++) begin
      wr(ADDR_POINTER, 8'(c)); rd(ADDR_MODE, 8'(c % 2));
    end
    sz = 2 + $urandom % 8;
    wr(ADDR_POINTER, 8'h02); wr(ADDR_SIZE_LO, 8'(sz));
    wr(ADDR_ACTIVE, 8'h84); rd(ADDR_ACTIVE, 8'h04);
    wr(ADDR_ACTIVE, 8'h00); rd(ADDR_ACTIVE, 8'h04);
    send(sz, 3'h2, 0);
    drain;
    rd(ADDR_ACTIVE, 8'h00); rd(ADDR_FULL, 8'h04); rd(ADDR_HALF, 8'h04);
    wr(ADDR_FULL, 8'h00); rd(ADDR_FULL, 8'h00);
    sz = 20;
    wr(ADDR_POINTER, 8'h01); wr(ADDR_SIZE_LO, 8'h14); wr(ADDR_ACTIVE, 8'h02);
    hold = 1;
    send(17, 3'h1, 0);
    repeat (3) @(posedge clk);
    #1 cmpR(8'h00, {7'h00, srcReady});
    hold = 0;
    send(5, 3'h1, 17);
    drain;
    rd(ADDR_ACTIVE, 8'h02); rd(ADDR_FULL, 8'h02);
    // stalled channel takes nothing, then resumes where it stopped
    wr(ADDR_CONFIG, 8'h20); rd(ADDR_CONFIG, 8'h20); rd(ADDR_OFS_LO, 8'h02);
    @(posedge clk) #1 srcValid = 1;
    repeat (6) @(posedge clk);
    #1 srcValid = 0;
    rd(ADDR_OFS_LO, 8'h02); rd(ADDR_OFS_HI, 8'h00);
    wr(ADDR_CONFIG, 8'h00); send(1, 3'h1, 2);
    drain;
    rd(ADDR_OFS_LO, 8'h03); rd(ADDR_SIZE_LO, 8'h14);
    report_and_stop;
  end
endmodule
bind mdc_dma_ctrl mdc_dma_ctrl_props chk (.clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr),
  .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
  .srcValid(srcValid), .srcData(srcData), .srcReady(srcReady), .memValid(memValid),
  .memData(memData), .memChan(memChan), .memOffset(memOffset), .memReady(memReady));

// >>> verification/mdc_ram_model.sv
`timescale 1ns/1ps
// data ram sink: random stalls, or none accepted while held
module mdc_ram_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic hold,
  // handshake
  output logic memReady
);
  // ready moves just after the edge
  initial memReady = 1'b0;
  always @(posedge clk) memReady <= #1 !hold && ($urandom % 4 != 0);
endmodule
